// File: shared/pfm_defines.svh
/*
  Offsets, field positions, reset values and widths of the pulse and frequency
  measurement timer. Assumes inclusion by bare name from the package and modules.
*/
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

// Register indexes; the byte address on the bus is four times the index.
`define PFM_IDX_MODE      8'ha0
`define PFM_IDX_CNT_LOW   8'ha1
`define PFM_IDX_CNT_HIGH  8'ha2
`define PFM_IDX_CONV      8'ha3
`define PFM_IDX_EDGE      8'hbf

// Timer mode register fields.
`define PFM_MODE_RUN      7
`define PFM_MODE_RATE_HI  6
`define PFM_MODE_RATE_LO  4
`define PFM_MODE_SRC      3
`define PFM_MODE_IEN      1
`define PFM_MODE_IRQ      0

// Edge control register fields.
`define PFM_EDGE_PW       1
`define PFM_EDGE_POL      0

// Converter control register fields.
`define PFM_CONV_CLKOUT   7
`define PFM_CONV_CH_HI    2
`define PFM_CONV_CH_LO    1
`define PFM_CONV_EN       0

// Reset values.
`define PFM_RST_MODE      8'h00
`define PFM_RST_EDGE      2'h0
`define PFM_RST_COUNT     16'h0000
`define PFM_RST_CONV      8'h00
`define PFM_RST_RATE      3'h0

// Channel code with no channel behind it.
`define PFM_CH_RESERVED   2'h3
`define PFM_NUM_CH        3

// Prescaler counter width; code 000 divides by two to this power.
`define PFM_PRE_W         8

// Bus constants.
`define PFM_HTRANS_NONSEQ 2'h2
`define PFM_HRESP_OKAY    1'h0

`endif

// File: shared/pfm_pkg.sv
/*
  Types of the pulse and frequency measurement timer.
  Assumes pfm_defines.svh is on the include path.
*/
`include "pfm_defines.svh"

package pfm_pkg;

  typedef enum logic [1:0] {
    PFM_PW_WAIT,
    PFM_PW_COUNT,
    PFM_PW_DONE
  } pfm_pw_state_t;

  typedef struct packed {
    logic [3:0]              takeover;
    logic [`PFM_NUM_CH-1:0] chan_en;
    logic [`PFM_NUM_CH-1:0] chan_analog;
    logic                    clk_out_sel;
    logic                    clk_out;
  } pfm_pins_t;

endpackage

// File: tb/pfm_pulse_src.sv
/*
  Model of the external pulse signal and the converter clock.
  Assumes the bench calls its tasks just after a rising edge of hclk.
*/
`timescale 1ns/1ps

module pfm_pulse_src (
  input wire logic hclk,
  output logic     event_input,
  output logic     osc_clk_in
);
  initial begin
    event_input = 1'b0;
    osc_clk_in  = 1'b0;
  end

  task automatic set_level(input logic osc, input logic v);
    if (osc) osc_clk_in <= v;
    else event_input <= v;
  endtask

  task automatic burst(input logic osc, input int n, input int half);
    repeat (n) begin
      set_level(osc, 1'b1);
      repeat (half) @(posedge hclk);
      set_level(osc, 1'b0);
      repeat (half) @(posedge hclk);
    end
  endtask
endmodule

// File: tb/pfm_timer_assertions.sv
/*
  Checker of the timer's bus answers and converter pin outputs.
  Assumes it is bound to pfm_timer and sees only its ports.
*/
`timescale 1ns/1ps

module pfm_timer_assertions
  import pfm_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        event_input,
  input wire logic        osc_clk_in,
  input wire pfm_pins_t   pins
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic req;
  assign req = hsel && hready && htrans == 2'h2;

  read_wait_a: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (req && hwrite |=> hreadyout)
    else $error("write stalled");
  rdata_width_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chan_onehot_a: assert property ($onehot0(pins.chan_en))
    else $error("more than one channel on");
  chan_analog_a: assert property (
    pins.takeover == 4'hf |-> pins.chan_analog == ~pins.chan_en)
    else $error("analog pins wrong");
  takeover_all_a: assert property (pins.takeover == 4'h0 || pins.takeover == 4'hf)
    else $error("partial pin takeover");
  conv_off_a: assert property (
    pins.takeover == 4'h0 |-> pins.chan_en == 3'h0 &&
    pins.chan_analog == 3'h0 && !pins.clk_out)
    else $error("converter pins active while off");
  clk_copy_a: assert property (
    pins.clk_out_sel && pins.takeover == 4'hf |-> pins.clk_out == $past(osc_clk_in))
    else $error("converter clock copy wrong");

  cover property (req && !hwrite);
  cover property (pins.takeover == 4'hf && pins.chan_en == 3'h0);
  cover property ($rose(pins.clk_out) && pins.clk_out_sel);
endmodule

bind pfm_timer pfm_timer_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .event_input,
  .osc_clk_in, .pins);

// File: tb/pulse_freq_measure_timer_tb.sv
/*
  Self-checking bench of the measurement timer over AHB-Lite.
  Assumes the checker is bound and the pulse source model drives the inputs.
*/
`timescale 1ns/1ps
`include "pfm_defines.svh"

module pulse_freq_measure_timer_tb;
  import pfm_pkg::*;
  typedef struct packed {logic [7:0] conv; logic [11:0] pins;} pfm_row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        event_input, osc_clk_in;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [15:0] c, c2;
  pfm_pins_t   pins;
  int          bad_count, tests_run, cycles;
  pfm_row_t    rows [6] = '{'{8'h01, 12'hf38}, '{8'h03, 12'hf54}, '{8'h05, 12'hf8c},
                            '{8'h07, 12'hf1c}, '{8'h80, 12'h002}, '{8'h00, 12'h000}};
  logic [7:0]  idx [6] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'hbf, 8'h10};

  pfm_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_input(event_input),
    .osc_clk_in(osc_clk_in), .pins(pins));
  pfm_pulse_src src_u (.hclk(hclk), .event_input(event_input), .osc_clk_in(osc_clk_in));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wt;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    haddr <= {22'h0, a, 2'h0};
    hwrite <= 1'b1;
    htrans <= `PFM_HTRANS_NONSEQ;
    wt();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt();
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    haddr <= {22'h0, a, 2'h0};
    hwrite <= 1'b0;
    htrans <= `PFM_HTRANS_NONSEQ;
    wt();
    htrans <= 2'h0;
    wt();
    d = hrdata;
  endtask
  task automatic rcnt(output logic [15:0] v);
    logic [31:0] t;
    rdr(`PFM_IDX_CNT_HIGH, t);
    v[15:8] = t[7:0];
    rdr(`PFM_IDX_CNT_LOW, t);
    v[7:0] = t[7:0];
  endtask
  task automatic freq(input logic [7:0] e, input logic [7:0] cv, input logic osc,
                      input int n, input logic [15:0] exp);
    wr(`PFM_IDX_EDGE, e);
    wr(`PFM_IDX_CONV, cv);
    wr(`PFM_IDX_MODE, 8'h88);
    src_u.burst(!osc, 2, 3);
    src_u.burst(osc, n, 3);
    idle(2);
    wr(`PFM_IDX_MODE, 8'h08);
    src_u.burst(osc, 2, 3);
    rcnt(c);
    chk({16'h0, c}, {16'h0, exp});
  endtask

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    idle(4);
    hresetn <= 1'b1;
    wr(8'h10, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rdr(idx[i], rd);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      wr(`PFM_IDX_CONV, rows[i].conv);
      idle(2);
      chk({20'h0, pins}, {20'h0, rows[i].pins});
      rdr(`PFM_IDX_CONV, rd);
      chk(rd, {24'h0, rows[i].conv});
    end
    wr(`PFM_IDX_CNT_LOW, 8'h34);
    wr(`PFM_IDX_CNT_HIGH, 8'h12);
    rcnt(c);
    chk({16'h0, c}, 32'h1234);
    wr(`PFM_IDX_CNT_LOW, 8'h00);
    wr(`PFM_IDX_CNT_HIGH, 8'h00);
    freq(8'h01, 8'h00, 1'b0, 5, 16'd5);
    freq(8'h00, 8'h00, 1'b0, 4, 16'd9);
    freq(8'h00, 8'h01, 1'b1, 3, 16'd12);
    wr(`PFM_IDX_CNT_LOW, 8'hfe);
    wr(`PFM_IDX_CNT_HIGH, 8'hff);
    wr(`PFM_IDX_MODE, 8'he0);
    idle(12);
    rdr(`PFM_IDX_MODE, rd);
    chk(rd, 32'he1);
    wr(`PFM_IDX_MODE, 8'h00);
    rcnt(c);
    chk({31'h0, c >= 16'd2 && c <= 16'd3}, 32'h1);
    wr(`PFM_IDX_CONV, 8'h00);
    wr(`PFM_IDX_CNT_LOW, 8'h00);
    wr(`PFM_IDX_CNT_HIGH, 8'h00);
    wr(`PFM_IDX_EDGE, 8'h02);
    wr(`PFM_IDX_MODE, 8'hf0);
    idle(3);
    src_u.set_level(1'b0, 1'b1);
    idle(40);
    src_u.set_level(1'b0, 1'b0);
    idle(4);
    rdr(`PFM_IDX_MODE, rd);
    chk(rd, 32'hf1);
    rcnt(c);
    chk({31'h0, c >= 16'd19 && c <= 16'd21}, 32'h1);
    src_u.set_level(1'b0, 1'b1);
    idle(10);
    src_u.set_level(1'b0, 1'b0);
    rcnt(c2);
    chk({16'h0, c2}, {16'h0, c});
    wr(`PFM_IDX_EDGE, 8'h03);
    wr(`PFM_IDX_CNT_LOW, 8'h00);
    wr(`PFM_IDX_CNT_HIGH, 8'h00);
    wr(`PFM_IDX_MODE, 8'hf0);
    src_u.set_level(1'b0, 1'b1);
    idle(6);
    src_u.set_level(1'b0, 1'b0);
    idle(10);
    rcnt(c);
    chk({31'h0, c >= 16'd3 && c <= 16'd8}, 32'h1);
    idle(24);
    src_u.set_level(1'b0, 1'b1);
    idle(4);
    rdr(`PFM_IDX_MODE, rd);
    chk(rd, 32'hf1);
    rcnt(c);
    chk({31'h0, c >= 16'd18 && c <= 16'd22}, 32'h1);
    wr(`PFM_IDX_CONV, 8'h83);
    src_u.set_level(1'b1, 1'b1);
    idle(2);
    chk({20'h0, pins}, 32'hf57);
    hresetn <= 1'b0;
    idle(2);
    hresetn <= 1'b1;
    chk({20'h0, pins}, 32'h0);
    rdr(`PFM_IDX_CONV, rd);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule

// File: verilog/pfm_prescaler.sv
/*
  Prescaler that divides the instruction clock by 256 down to 2.
  Assumes hclk is the instruction clock and rate is stable between uses.
*/
`timescale 1ns/1ps
`include "pfm_defines.svh"

module pfm_prescaler
  import pfm_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [2:0] rate,
  output logic            tick
);

  logic [`PFM_PRE_W-1:0] cnt_r;
  logic [`PFM_PRE_W-1:0] mask;

  // Code 000 watches all eight bits, code 111 only the lowest one.
  assign mask = 8'hff >> rate;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= ((cnt_r & mask) == mask);
    end
  end

endmodule

// File: verilog/pfm_timer.sv
/*
  Pulse and frequency measurement timer with converter control, AHB-Lite slave.
  Assumes event_input and osc_clk_in are synchronous to hclk and one AHB master.
*/
`timescale 1ns/1ps
`include "pfm_defines.svh"

module pfm_timer
  import pfm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        event_input,
  input  wire logic        osc_clk_in,
  output pfm_pins_t        pins
);

  // Register selector, used by both the write and the read decoders.
  typedef enum logic [2:0] {
    PFM_SEL_NONE,
    PFM_SEL_MODE,
    PFM_SEL_LOW,
    PFM_SEL_HIGH,
    PFM_SEL_CONV,
    PFM_SEL_EDGE
  } pfm_sel_t;

  function automatic pfm_sel_t decode_addr(input logic [31:0] a);
    pfm_sel_t s;
    s = PFM_SEL_NONE;
    if (a[1:0] != 2'h0 || a[31:10] != 22'h0) begin
      s = PFM_SEL_NONE;
    end else if (a[9:2] == `PFM_IDX_MODE) begin
      s = PFM_SEL_MODE;
    end else if (a[9:2] == `PFM_IDX_CNT_LOW) begin
      s = PFM_SEL_LOW;
    end else if (a[9:2] == `PFM_IDX_CNT_HIGH) begin
      s = PFM_SEL_HIGH;
    end else if (a[9:2] == `PFM_IDX_CONV) begin
      s = PFM_SEL_CONV;
    end else if (a[9:2] == `PFM_IDX_EDGE) begin
      s = PFM_SEL_EDGE;
    end
    return s;
  endfunction

  // One-hot channel enable; the reserved code yields none.
  function automatic logic [`PFM_NUM_CH-1:0] chan_onehot(input logic [1:0] code);
    logic [`PFM_NUM_CH-1:0] oh;
    oh = 3'h0;
    if (code != `PFM_CH_RESERVED) begin
      oh = 3'h1 << code;
    end
    return oh;
  endfunction

  logic                    ap_valid_r;
  logic                    ap_write_r;
  pfm_sel_t                ap_sel_r;
  logic                    wr_mode;
  logic                    wr_low;
  logic                    wr_high;
  logic                    wr_conv;
  logic                    wr_edge;
  logic                    rd_high;
  logic [7:0]              wbyte;

  logic                    run_r;
  logic [2:0]              rate_r;
  logic                    src_sel_r;
  logic                    ien_r;
  logic                    irq_r;
  logic                    pw_en_r;
  logic                    pol_r;
  logic                    conv_en_r;
  logic [1:0]              chan_r;
  logic                    clk_out_en_r;
  logic [15:0]             count_r;
  logic [15:0]             count_nxt;
  logic [7:0]              low_wr_r;
  logic [7:0]              low_rd_r;
  pfm_pw_state_t           pw_state_r;

  logic                    tick;
  logic                    sig;
  logic                    sig_prev_r;
  logic                    rise;
  logic                    fall;
  logic                    edge_hit;
  logic                    start_edge;
  logic                    stop_edge;
  logic                    cnt_inc;
  logic                    overflow;
  logic                    pw_stop;

  logic [3:0]              takeover_r;
  logic [`PFM_NUM_CH-1:0]  chan_en_r;
  logic [`PFM_NUM_CH-1:0]  chan_an_r;
  logic [`PFM_NUM_CH-1:0]  chan_oh;
  logic                    clk_sel_r;
  logic                    clk_drv_r;

  pfm_prescaler u_pre (
    .hclk    (hclk),
    .hresetn (hresetn),
    .rate    (rate_r),
    .tick    (tick)
  );

  // Bus address phase capture.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_sel_r   <= PFM_SEL_NONE;
    end else if (hready) begin
      ap_valid_r <= hsel && htrans == `PFM_HTRANS_NONSEQ;
      ap_write_r <= hwrite;
      ap_sel_r   <= decode_addr(haddr);
    end
  end

  assign wbyte   = hwdata[7:0];
  assign wr_mode = ap_valid_r && ap_write_r && ap_sel_r == PFM_SEL_MODE;
  assign wr_low  = ap_valid_r && ap_write_r && ap_sel_r == PFM_SEL_LOW;
  assign wr_high = ap_valid_r && ap_write_r && ap_sel_r == PFM_SEL_HIGH;
  assign wr_conv = ap_valid_r && ap_write_r && ap_sel_r == PFM_SEL_CONV;
  assign wr_edge = ap_valid_r && ap_write_r && ap_sel_r == PFM_SEL_EDGE;
  assign rd_high = ap_valid_r && !ap_write_r && !hreadyout && ap_sel_r == PFM_SEL_HIGH;

  // Reads take one wait state so that read data comes from a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else if (hready && hsel && htrans == `PFM_HTRANS_NONSEQ && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (!hreadyout) begin
      hreadyout <= 1'b1;
      if (ap_sel_r == PFM_SEL_MODE) begin
        hrdata <= {24'h0, run_r, rate_r, src_sel_r, 1'b0, ien_r, irq_r};
      end else if (ap_sel_r == PFM_SEL_LOW) begin
        hrdata <= {24'h0, low_rd_r};
      end else if (ap_sel_r == PFM_SEL_HIGH) begin
        hrdata <= {24'h0, count_r[15:8]};
      end else if (ap_sel_r == PFM_SEL_CONV) begin
        hrdata <= {24'h0, clk_out_en_r, 4'h0, chan_r, conv_en_r};
      end else if (ap_sel_r == PFM_SEL_EDGE) begin
        hrdata <= {30'h0, pw_en_r, pol_r};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= `PFM_HRESP_OKAY;
    end else begin
      hresp <= `PFM_HRESP_OKAY;
    end
  end

  // Timer mode register other than the flag.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r     <= 1'b0;
      rate_r    <= `PFM_RST_RATE;
      src_sel_r <= 1'b0;
      ien_r     <= 1'b0;
    end else if (wr_mode) begin
      run_r     <= wbyte[`PFM_MODE_RUN];
      rate_r    <= wbyte[`PFM_MODE_RATE_HI:`PFM_MODE_RATE_LO];
      src_sel_r <= wbyte[`PFM_MODE_SRC];
      ien_r     <= wbyte[`PFM_MODE_IEN];
    end
  end

  // Edge control register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_en_r <= 1'b0;
      pol_r   <= 1'b0;
    end else if (wr_edge) begin
      pw_en_r <= wbyte[`PFM_EDGE_PW];
      pol_r   <= wbyte[`PFM_EDGE_POL];
    end
  end

  // Converter control register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_en_r    <= 1'b0;
      chan_r       <= 2'h0;
      clk_out_en_r <= 1'b0;
    end else if (wr_conv) begin
      conv_en_r    <= wbyte[`PFM_CONV_EN];
      chan_r       <= wbyte[`PFM_CONV_CH_HI:`PFM_CONV_CH_LO];
      clk_out_en_r <= wbyte[`PFM_CONV_CLKOUT];
    end
  end

  // Input selection and edge detection.
  assign sig  = conv_en_r ? osc_clk_in : event_input;
  assign rise = sig && !sig_prev_r;
  assign fall = !sig && sig_prev_r;
  assign edge_hit   = pol_r ? rise : fall;
  assign start_edge = pol_r ? fall : rise;
  assign stop_edge  = pol_r ? rise : fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_prev_r <= 1'b0;
    end else begin
      sig_prev_r <= sig;
    end
  end

  // Pulse width sequence.
  assign pw_stop = run_r && pw_en_r && pw_state_r == PFM_PW_COUNT && stop_edge;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_state_r <= PFM_PW_WAIT;
    end else if (!run_r || !pw_en_r) begin
      pw_state_r <= PFM_PW_WAIT;
    end else begin
      case (pw_state_r)
        PFM_PW_WAIT: begin
          if (!irq_r && start_edge) begin
            pw_state_r <= PFM_PW_COUNT;
          end
        end
        PFM_PW_COUNT: begin
          if (stop_edge) begin
            pw_state_r <= PFM_PW_DONE;
          end
        end
        default: begin
          if (!irq_r) begin
            pw_state_r <= PFM_PW_WAIT;
          end
        end
      endcase
    end
  end

  // Counter advance conditions per mode.
  always_comb begin
    cnt_inc = 1'b0;
    if (run_r) begin
      if (pw_en_r) begin
        cnt_inc = pw_state_r == PFM_PW_COUNT && !stop_edge && tick;
      end else if (src_sel_r) begin
        cnt_inc = edge_hit;
      end else begin
        cnt_inc = tick;
      end
    end
  end

  assign overflow  = cnt_inc && count_r == 16'hffff;
  assign count_nxt = count_r + 16'h0001;

  // Buffer holds still while the timer is stopped, except that a high byte write loads it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= `PFM_RST_COUNT;
    end else if (wr_high) begin
      count_r <= {wbyte, low_wr_r};
    end else if (cnt_inc) begin
      count_r <= count_nxt;
    end
  end

  // Low byte: write staging and read snapshot.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_wr_r <= 8'h00;
    end else if (wr_low) begin
      low_wr_r <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_rd_r <= 8'h00;
    end else if (rd_high) begin
      low_rd_r <= count_r[7:0];
    end else if (pw_stop) begin
      low_rd_r <= count_r[7:0];
    end
  end

  // Flag: a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else if (pw_stop || (overflow && !pw_en_r)) begin
      irq_r <= 1'b1;
    end else if (wr_mode) begin
      irq_r <= wbyte[`PFM_MODE_IRQ];
    end
  end

  // Port 5 pin takeover and channel states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      takeover_r <= 4'h0;
      clk_sel_r  <= 1'b0;
      clk_drv_r  <= 1'b0;
    end else begin
      takeover_r <= {4{conv_en_r}};
      clk_sel_r  <= clk_out_en_r;
      clk_drv_r  <= clk_out_en_r && conv_en_r && osc_clk_in;
    end
  end

  assign chan_oh = chan_onehot(chan_r);

  genvar gi;
  generate
    for (gi = 0; gi < `PFM_NUM_CH; gi = gi + 1) begin : g_chan
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          chan_en_r[gi] <= 1'b0;
          chan_an_r[gi] <= 1'b0;
        end else begin
          chan_en_r[gi] <= conv_en_r && chan_oh[gi];
          chan_an_r[gi] <= conv_en_r && !chan_oh[gi];
        end
      end
    end
  endgenerate

  assign pins.takeover    = takeover_r;
  assign pins.chan_en     = chan_en_r;
  assign pins.chan_analog = chan_an_r;
  assign pins.clk_out_sel = clk_sel_r;
  assign pins.clk_out     = clk_drv_r;

endmodule
